/* rtl/pfc_pwm_defs.vh */
// constants for the dual-slope phase and frequency correct pwm timer
`ifndef PFC_PWM_DEFS_VH
`define PFC_PWM_DEFS_VH
`define MODE_PFC_CAPTURE_TOP 4'h8
`define MODE_PFC_COMPARE_TOP 4'h9
`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_NONINV 2'h2
`define ACT_INV 2'h3
`define PRESC_STOP 3'h0
`define PRESC_DIV1 3'h1
`define PRESC_DIV8 3'h2
`define PRESC_DIV64 3'h3
`define PRESC_DIV256 3'h4
`define PRESC_DIV1024 3'h5
`define DIV8_LAST 10'h007
`define DIV64_LAST 10'h03f
`define DIV256_LAST 10'h0ff
`define DIV1024_LAST 10'h3ff
`define COUNT_BOTTOM 16'h0000
`define COUNT_RESET 16'h0000
`define COMPARE_RESET 16'h0000
`endif

/* rtl/pfc_pwm_timer16.v */
// phase and frequency correct dual-slope 16-bit pwm timer
`timescale 1ns/1ps
`include "pfc_pwm_defs.vh"
module pfc_pwm_timer16 (
    input wire sys_clk, // 125 mhz i/o clock
    input wire resetn, // async reset, active low
    input wire [3:0] waveform_mode_sel, // waveform mode code
    input wire [2:0] clock_select, // prescaler select
    input wire [1:0] out_action_a, // output action, channel a
    input wire [1:0] out_action_b, // output action, channel b
    input wire [15:0] compare_buf_a, // software compare a value
    input wire [15:0] compare_buf_b, // software compare b value
    input wire [15:0] capture_value_reg, // capture value register
    input wire pin_dir_out_a, // pin a direction is output
    input wire pin_dir_out_b, // pin b direction is output
    input wire port_data_a, // normal port level, pin a
    input wire port_data_b, // normal port level, pin b
    input wire clear_match_flag_a, // clear pulse for match flag a
    input wire clear_match_flag_b, // clear pulse for match flag b
    input wire clear_overflow_flag, // clear pulse for overflow flag
    input wire clear_capture_flag, // clear pulse for capture flag
    output wire [15:0] counter_value, // current count
    output wire [15:0] compare_value_a, // active compare a
    output wire [15:0] compare_value_b, // active compare b
    output wire match_flag_a, // sticky match flag a
    output wire match_flag_b, // sticky match flag b
    output wire overflow_flag, // sticky overflow flag
    output wire capture_flag, // sticky capture flag
    output wire count_down, // counting direction, high when down
    output wire wave_out_a, // internal waveform a
    output wire wave_out_b, // internal waveform b
    output wire pin_out_a, // pin a level
    output wire pin_oe_n_a, // pin a driver enable, low drives
    output wire pin_out_b, // pin b level
    output wire pin_oe_n_b // pin b driver enable, low drives
);
    reg [9:0] presc_ff;
    reg [15:0] cnt_ff, cmp_a_ff, cmp_b_ff;
    reg down_ff, wave_a_ff, wave_b_ff;
    reg mflag_a_ff, mflag_b_ff, ovf_ff, cap_ff;
    reg [15:0] nxt_cnt;
    reg nxt_down, nxt_wave_a, nxt_wave_b;
    reg timer_tick;

    wire pfc_mode = (waveform_mode_sel == `MODE_PFC_CAPTURE_TOP) ||
                    (waveform_mode_sel == `MODE_PFC_COMPARE_TOP);
    wire top_from_a = (waveform_mode_sel == `MODE_PFC_COMPARE_TOP);
    wire [15:0] top_value = top_from_a ? cmp_a_ff : capture_value_reg;
    wire at_top = (cnt_ff == top_value);
    wire at_bottom = (cnt_ff == `COUNT_BOTTOM);
    // equality only; a compare above top simply never matches
    wire match_a = (cnt_ff == cmp_a_ff);
    wire match_b = (cnt_ff == cmp_b_ff);
    wire run = pfc_mode && timer_tick;

    // free-running divider; tick is an enable, not a clock
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            presc_ff <= 10'h000;
        else
            presc_ff <= presc_ff + 10'h001;
    end

    // true when every bit selected by the mask is set
    function low_bits_full;
        input [9:0] value;
        input [9:0] mask;
        begin
            low_bits_full = ((value & mask) == mask);
        end
    endfunction

    always @* begin
        case (clock_select)
            `PRESC_DIV1: timer_tick = 1'b1;
            `PRESC_DIV8: timer_tick = low_bits_full(presc_ff, `DIV8_LAST);
            `PRESC_DIV64: timer_tick = low_bits_full(presc_ff, `DIV64_LAST);
            `PRESC_DIV256: timer_tick = low_bits_full(presc_ff, `DIV256_LAST);
            `PRESC_DIV1024: timer_tick = low_bits_full(presc_ff, `DIV1024_LAST);
            default: timer_tick = 1'b0;
        endcase
    end

    // pwm level rule: clear on up-match, set on down-match (non-inverting)
    function pwm_next;
        input [1:0] act;
        input cur;
        input hit;
        input dn;
        begin
            pwm_next = cur;
            if (hit) begin
                case (act)
                    `ACT_NONINV: pwm_next = dn;
                    `ACT_INV: pwm_next = ~dn;
                    default: pwm_next = cur;
                endcase
            end
        end
    endfunction

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_down = down_ff;
        nxt_wave_a = wave_a_ff;
        nxt_wave_b = wave_b_ff;
        if (run) begin
            // direction flips while sitting at top, so top lasts one tick
            if (!down_ff && at_top) begin
                nxt_down = 1'b1;
                nxt_cnt = cnt_ff - 16'h0001;
            end else if (down_ff && at_bottom) begin
                nxt_down = 1'b0;
                nxt_cnt = cnt_ff + 16'h0001;
            end else if (down_ff) begin
                nxt_cnt = cnt_ff - 16'h0001;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
            // a match takes the slope that follows it: top as down, bottom as up,
            // which gives steady low at compare 0 and steady high at top
            if (out_action_a == `ACT_TOGGLE && top_from_a) begin
                if (match_a)
                    nxt_wave_a = ~wave_a_ff;
            end else begin
                nxt_wave_a = pwm_next(out_action_a, wave_a_ff, match_a,
                                      nxt_down);
            end
            nxt_wave_b = pwm_next(out_action_b, wave_b_ff, match_b,
                                  nxt_down);
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= `COUNT_RESET;
            down_ff <= 1'b0;
            cmp_a_ff <= `COMPARE_RESET;
            cmp_b_ff <= `COMPARE_RESET;
            wave_a_ff <= 1'b0;
            wave_b_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            down_ff <= nxt_down;
            wave_a_ff <= nxt_wave_a;
            wave_b_ff <= nxt_wave_b;
            // reloading only at bottom keeps both slopes equal
            if (run && at_bottom) begin
                cmp_a_ff <= compare_buf_a;
                cmp_b_ff <= compare_buf_b;
            end
        end
    end

    // flags: a hardware set beats a same-cycle software clear
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mflag_a_ff <= 1'b0;
            mflag_b_ff <= 1'b0;
            ovf_ff <= 1'b0;
            cap_ff <= 1'b0;
        end else begin
            if (run && match_a)
                mflag_a_ff <= 1'b1;
            else if (clear_match_flag_a)
                mflag_a_ff <= 1'b0;
            if (run && match_b)
                mflag_b_ff <= 1'b1;
            else if (clear_match_flag_b)
                mflag_b_ff <= 1'b0;
            if (run && at_bottom)
                ovf_ff <= 1'b1;
            else if (clear_overflow_flag)
                ovf_ff <= 1'b0;
            if (run && at_top && !top_from_a)
                cap_ff <= 1'b1;
            else if (clear_capture_flag)
                cap_ff <= 1'b0;
        end
    end

    // channel b has no toggle; action 1 leaves it on the port
    wire conn_a = (out_action_a != `ACT_OFF) &&
                  (out_action_a != `ACT_TOGGLE || top_from_a);
    wire conn_b = (out_action_b == `ACT_NONINV) || (out_action_b == `ACT_INV);

    assign pin_out_a = conn_a ? wave_a_ff : port_data_a;
    assign pin_out_b = conn_b ? wave_b_ff : port_data_b;
    assign pin_oe_n_a = ~pin_dir_out_a;
    assign pin_oe_n_b = ~pin_dir_out_b;

    assign counter_value = cnt_ff;
    assign compare_value_a = cmp_a_ff;
    assign compare_value_b = cmp_b_ff;
    assign match_flag_a = mflag_a_ff;
    assign match_flag_b = mflag_b_ff;
    assign overflow_flag = ovf_ff;
    assign capture_flag = cap_ff;
    assign count_down = down_ff;
    assign wave_out_a = wave_a_ff;
    assign wave_out_b = wave_b_ff;
endmodule

/* tb/pfc_pwm_monitor.sv */
// assertion checker for the dual-slope pwm timer ports
`timescale 1ns/1ps
module pfc_pwm_monitor (
    input wire sys_clk, // clock
    input wire resetn, // reset
    input wire [3:0] waveform_mode_sel, // mode
    input wire [2:0] clock_select, // prescaler
    input wire [1:0] out_action_a, // action a
    input wire pin_dir_out_a, // dir a
    input wire [15:0] counter_value, // count
    input wire [15:0] compare_value_a, // active cmp a
    input wire [15:0] compare_buf_a, // buffered cmp a
    input wire overflow_flag, // ovf
    input wire match_flag_a, // flag a
    input wire count_down, // direction
    input wire wave_out_a, // wave a
    input wire pin_out_a, // pin a
    input wire pin_oe_n_a // oe a
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!resetn);
wire pfc = waveform_mode_sel[3:1] == 3'h4;
wire run = pfc && clock_select == 3'h1;
a_count_up: assert property (run && waveform_mode_sel[0] && !count_down &&
    counter_value < compare_value_a |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("count did not step up");
a_count_down: assert property (run && count_down && counter_value != 16'h0000
    |=> count_down && counter_value == $past(counter_value) - 16'h0001)
    else $error("count did not step down");
a_top_turn: assert property (run && waveform_mode_sel[0] && !count_down &&
    counter_value == compare_value_a && counter_value != 16'h0000
    |=> count_down && match_flag_a && counter_value == $past(counter_value) - 16'h0001)
    else $error("no turn at top");
a_stop_frozen: assert property (!pfc || clock_select == 3'h0 || clock_select > 3'h5
    |=> $stable(counter_value)) else $error("count moved while stopped");
a_bottom_reload: assert property (run && counter_value == 16'h0000
    |=> overflow_flag && compare_value_a == $past(compare_buf_a)) else $error("bottom reload");
a_compare_held: assert property (counter_value != 16'h0000 |=> $stable(compare_value_a))
    else $error("compare changed off bottom");
a_pin_enable: assert property (pin_oe_n_a == !pin_dir_out_a)
    else $error("pin enable wrong");
a_pin_wave: assert property (out_action_a == 2'h2 |-> pin_out_a == wave_out_a)
    else $error("pin does not follow wave");
a_toggle_top: assert property (run && waveform_mode_sel[0] && out_action_a == 2'h1 &&
    counter_value == compare_value_a && counter_value != 16'h0000
    |=> wave_out_a != $past(wave_out_a)) else $error("no toggle at match");
cover property (run && counter_value == 16'h0000);
cover property (run && count_down && waveform_mode_sel[0]);
cover property (out_action_a == 2'h1 && $changed(wave_out_a));
endmodule

/* tb/pfc_pwm_timer16_bench.sv */
// self-checking bench for the dual-slope pwm timer
`timescale 1ns/1ps
module pfc_pwm_timer16_bench;
reg sys_clk = 1'b0;
reg resetn = 1'b0;
reg [3:0] mode = 4'h8;
reg [2:0] cs = 3'h1;
reg [1:0] act_a = 2'h2, act_b = 2'h3;
reg [15:0] buf_a = 16'h0007, buf_b = 16'h0003, cap = 16'h0005;
reg dir_a = 1'b1, dir_b = 1'b1, clr_a = 1'b0, clr_b = 1'b0, clr_o = 1'b0, clr_c = 1'b0;
reg [31:0] seed = 32'h0000002e, r;
wire [15:0] counter_value, high_cnt, cmp_b;
wire overflow_flag, match_flag_b, capture_flag, pout_b, oen_b, wave_b;
integer n_fail = 0, cmp_count = 0, cyc = 0, h;
integer cnt, dn, ca, cb, top, ovf, fb, cf, psc, tk, wb;
pfc_pwm_timer16 DUT (.sys_clk(sys_clk), .resetn(resetn), .waveform_mode_sel(mode),
    .clock_select(cs), .out_action_a(act_a), .out_action_b(act_b), .compare_buf_a(buf_a),
    .compare_buf_b(buf_b), .capture_value_reg(cap), .pin_dir_out_a(dir_a), .pin_dir_out_b(dir_b),
    .port_data_a(1'b0), .port_data_b(1'b0), .clear_match_flag_a(clr_a), .clear_match_flag_b(clr_b),
    .clear_overflow_flag(clr_o), .clear_capture_flag(clr_c), .counter_value(counter_value),
    .compare_value_a(), .compare_value_b(cmp_b), .match_flag_a(), .match_flag_b(match_flag_b),
    .overflow_flag(overflow_flag), .capture_flag(capture_flag), .count_down(), .wave_out_a(),
    .wave_out_b(wave_b), .pin_out_a(), .pin_oe_n_a(), .pin_out_b(pout_b), .pin_oe_n_b(oen_b));
pwm_load_model load (.sys_clk(sys_clk), .pin_level(pout_b), .pin_oe_n(oen_b), .high_cnt(high_cnt));
initial forever #4 sys_clk = ~sys_clk;
function [31:0] rnd();
    begin
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed;
    end
endfunction
// reference model; clears applied first so a same-tick set wins
always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        cnt = 0; dn = 0; ca = 0; cb = 0; ovf = 0; fb = 0; cf = 0; psc = 0; wb = 0;
    end else begin
        tk = (cs == 1) || (cs == 2 && psc % 8 == 7);
        psc = (psc + 1) % 1024;
        top = (mode == 9) ? ca : cap;
        if (clr_o) ovf = 0;
        if (clr_b) fb = 0;
        if (clr_c) cf = 0;
        if (tk && (mode == 8 || mode == 9)) begin
            if (cnt == cb) fb = 1;
            // a match takes the slope it starts: top falls, bottom rises
            if (cnt == cb && act_b[1]) wb = act_b[0] ^ ((!dn && cnt == top) || (dn && cnt != 0));
            if (mode == 8 && cnt == top) cf = 1;
            if (cnt == 0) begin
                ovf = 1; ca = buf_a; cb = buf_b;
            end
            if (!dn && cnt == top) dn = 1;
            else if (dn && cnt == 0) dn = 0;
            cnt = dn ? cnt - 1 : cnt + 1;
        end
    end
end
task print_verdict;
    begin
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    end
endtask
task chk(input [15:0] got, input integer exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp[15:0]) begin
            n_fail = n_fail + 1;
            $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
        end
    end
endtask
task step(input integer n);
    integer i;
    begin
        for (i = 0; i < n; i = i + 1) begin
            @(negedge sys_clk);
            chk(counter_value, cnt);
            chk({15'h0000, overflow_flag}, ovf);
            chk({15'h0000, match_flag_b}, fb);
            chk({15'h0000, capture_flag}, cf);
            chk(cmp_b, cb);
            chk({15'h0000, wave_b}, wb);
            r = rnd() & rnd();
            {clr_a, clr_b, clr_o, clr_c} = r[3:0];
        end
    end
endtask
always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
        n_fail = n_fail + 1;
        print_verdict;
    end
end
initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    step(40);
    mode = 4'h9;
    act_a = 2'h1;
    r = rnd();
    buf_b = {14'h0000, r[1:0]} + 16'h0003;
    step(60);
    cs = 3'h2;
    step(100);
    cs = 3'h0;
    step(10);
    mode = 4'h0;
    cs = 3'h1;
    step(10);
    mode = 4'h9;
    buf_b = 16'h0008;
    step(40);
    act_b = 2'h2;
    buf_b = 16'h0000;
    // a new compare needs a reload and then a second bottom to show
    step(30);
    h = high_cnt;
    step(30);
    chk(high_cnt, h);
    buf_b = 16'h0007;
    step(30);
    h = high_cnt;
    step(30);
    chk(high_cnt, h + 30);
    dir_a = 1'b0;
    dir_b = 1'b0;
    step(1);
    h = high_cnt;
    step(10);
    chk(high_cnt, h);
    dir_a = 1'b1;
    dir_b = 1'b1;
    buf_a = 16'h000a;
    step(40);
    print_verdict;
end
endmodule
bind pfc_pwm_timer16 pfc_pwm_monitor mon (.sys_clk(sys_clk), .resetn(resetn),
    .waveform_mode_sel(waveform_mode_sel), .clock_select(clock_select),
    .out_action_a(out_action_a), .pin_dir_out_a(pin_dir_out_a), .counter_value(counter_value),
    .compare_value_a(compare_value_a), .compare_buf_a(compare_buf_a),
    .overflow_flag(overflow_flag), .match_flag_a(match_flag_a), .count_down(count_down),
    .wave_out_a(wave_out_a), .pin_out_a(pin_out_a), .pin_oe_n_a(pin_oe_n_a));

/* tb/pwm_load_model.sv */
// load model: pulled-down pin feeding a high-time counter
`timescale 1ns/1ps
module pwm_load_model (
    input wire sys_clk, // clock
    input wire pin_level, // driven level
    input wire pin_oe_n, // low when driven
    output reg [15:0] high_cnt // cycles seen high
);
wire line = pin_oe_n ? 1'b0 : pin_level; // pull-down holds a released pin low
initial high_cnt = 16'h0000;
always @(posedge sys_clk) high_cnt <= high_cnt + {15'h0000, line};
endmodule
